// ==== src/ddc_ctrl_pkg.sv ====
`default_nettype none
package ddc_ctrl_pkg;
  localparam int SAMPLE_W = 16;
  localparam int ADDR_W = 12;
  localparam logic [9:0] IDX_PIN_CHOICE = 10'h00f;
  localparam logic [9:0] IDX_OSC_CHOICE = 10'h010;
  localparam logic [9:0] IDX_RESET_POLICY = 10'h011;
  localparam logic [9:0] IDX_BAND0_GAIN = 10'h014;
  localparam logic [9:0] IDX_BAND1_GAIN = 10'h016;
  localparam logic [9:0] IDX_LATENCY = 10'h01e;
  localparam logic [9:0] IDX_WIDE_GAIN = 10'h01f;
  localparam int OSC_CHOICE_LSB = 0;
  localparam int POLICY_LSB = 0;
  localparam int GAIN_BIT = 0;
  localparam int PIN_CHOICE_BIT = 0;
  localparam int LATENCY_LSB = 4;
  localparam logic [1:0] OSC_CHOICE_RESET = 2'h0;
  localparam logic [1:0] POLICY_RESET = 2'h0;
  localparam logic [2:0] LATENCY_RESET = 3'h5;
  localparam logic [1:0] CHOICE_OSC1 = 2'h0;
  localparam logic [1:0] CHOICE_OSC2 = 2'h1;
  localparam logic [1:0] CHOICE_OSC3 = 2'h2;
  localparam logic [1:0] POLICY_EVERY = 2'h0;
  localparam logic [1:0] POLICY_RESYNC_ONE = 2'h1;
  localparam logic [1:0] POLICY_RESYNC_TWO = 2'h2;
  localparam logic [1:0] POLICY_START_ONLY = 2'h3;
  localparam logic [1:0] RESYNC_ONE_COUNT = 2'h1;
  localparam logic [1:0] RESYNC_TWO_COUNT = 2'h2;
  localparam logic [7:0] LATENCY_DEC_24_32 = 8'h10;
  localparam logic [7:0] LATENCY_DEC_16_20 = 8'h20;
  localparam logic [7:0] LATENCY_DEC_6_12 = 8'h40;
  localparam logic [7:0] LATENCY_DEC_4_10 = 8'h50;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// ==== src/gain_doubler.sv ====
`default_nettype none
module gain_doubler #(
  parameter int W = 16
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic double_en,
  input wire logic signed [W-1:0] sample_in,
  output logic signed [W:0] sample_out
);
  // One extra bit keeps the doubled value exact instead of saturating.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sample_out <= '0;
    end else if (double_en) begin
      sample_out <= {sample_in, 1'b0};
    end else begin
      sample_out <= {sample_in[W-1], sample_in};
    end
  end

  gain_double_a: assert property (@(posedge clk_sys) disable iff (reset)
    double_en |=> sample_out == $past(sample_in) * 2)
    else $error("Doubled sample is wrong.");
  // The reset term stops the attempt at the releasing edge from comparing with the cleared output.
  gain_pass_a: assert property (@(posedge clk_sys) disable iff (reset)
    !reset && !double_en |=> sample_out == $past(sample_in))
    else $error("Unscaled sample is wrong.");
endmodule
`default_nettype wire

// ==== src/reset_policy.sv ====
`default_nettype none
module reset_policy (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [1:0] policy,
  input wire logic ddc_start,
  input wire logic lmfc_event,
  input wire logic divider_resync,
  output logic dsp_reset
);
  logic [1:0] pending_reg;
  logic [1:0] pending_next;
  logic take;

  // A start arms one event; a resync arms one or two depending on policy.
  always_comb begin
    take = 1'b0;
    pending_next = pending_reg;
    case (policy)
      ddc_ctrl_pkg::POLICY_EVERY: begin
        take = lmfc_event;
      end
      ddc_ctrl_pkg::POLICY_RESYNC_ONE,
      ddc_ctrl_pkg::POLICY_RESYNC_TWO: begin
        take = lmfc_event && pending_reg != 2'h0;
        if (take) begin
          pending_next = pending_reg - 2'h1;
        end
        if (ddc_start) begin
          pending_next = ddc_ctrl_pkg::RESYNC_ONE_COUNT;
        end else if (divider_resync) begin
          pending_next = (policy == ddc_ctrl_pkg::POLICY_RESYNC_TWO) ?
            ddc_ctrl_pkg::RESYNC_TWO_COUNT : ddc_ctrl_pkg::RESYNC_ONE_COUNT;
        end
      end
      ddc_ctrl_pkg::POLICY_START_ONLY: begin
        take = ddc_start;
      end
      default: begin
        take = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pending_reg <= 2'h0;
    end else begin
      pending_reg <= pending_next;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      dsp_reset <= 1'b0;
    end else begin
      dsp_reset <= take;
    end
  end

  every_event_a: assert property (@(posedge clk_sys) disable iff (reset)
    policy == ddc_ctrl_pkg::POLICY_EVERY && lmfc_event |=> dsp_reset)
    else $error("Multiframe event did not reset.");
  start_only_a: assert property (@(posedge clk_sys) disable iff (reset)
    policy == ddc_ctrl_pkg::POLICY_START_ONLY |-> ##1 dsp_reset == $past(ddc_start))
    else $error("Start-only policy reset mismatch.");
  resync_two_a: assert property (@(posedge clk_sys) disable iff (reset)
    policy == ddc_ctrl_pkg::POLICY_RESYNC_TWO && divider_resync && !ddc_start
    |=> pending_reg == ddc_ctrl_pkg::RESYNC_TWO_COUNT)
    else $error("Resync did not arm two events.");
endmodule
`default_nettype wire

// ==== src/downconverter_control_regs.sv ====
`default_nettype none
module downconverter_control_regs (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic awvalid,
  output logic awready,
  input wire logic [11:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [11:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire logic [15:0] osc1_word,
  input wire logic [15:0] osc2_word,
  input wire logic [15:0] osc3_word,
  input wire logic [1:0] gpio_osc_choice,
  output logic [15:0] band1_osc_word,
  input wire logic ddc_start,
  input wire logic lmfc_event,
  input wire logic divider_resync,
  output logic dsp_reset,
  input wire logic signed [15:0] band0_in,
  input wire logic signed [15:0] band1_in,
  input wire logic signed [15:0] wide_in,
  output logic signed [16:0] band0_out,
  output logic signed [16:0] band1_out,
  output logic signed [16:0] wide_out,
  output logic [2:0] fixed_latency
);
  localparam int NPATH = 3;

  logic pin_choice_reg;
  logic [1:0] osc_choice_reg;
  logic [1:0] policy_reg;
  logic band0_gain_reg;
  logic band1_gain_reg;
  logic wide_gain_reg;
  logic [2:0] latency_reg;

  logic aw_held_reg;
  logic w_held_reg;
  logic [9:0] aw_index_reg;
  logic [7:0] w_byte_reg;
  logic w_lane_reg;
  logic do_write;
  logic write_hit;
  logic [9:0] ar_index;
  logic read_hit;
  logic [7:0] read_byte;
  logic [1:0] eff_choice;

  // Write address and data are each held until the other arrives.
  assign awready = !aw_held_reg && !bvalid;
  assign wready = !w_held_reg && !bvalid;
  assign arready = !rvalid;
  assign do_write = aw_held_reg && w_held_reg && !bvalid;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      aw_held_reg <= 1'b0;
      aw_index_reg <= 10'h000;
    end else if (awvalid && awready) begin
      aw_held_reg <= 1'b1;
      aw_index_reg <= awaddr[11:2];
    end else if (do_write) begin
      aw_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      w_held_reg <= 1'b0;
      w_byte_reg <= 8'h00;
      w_lane_reg <= 1'b0;
    end else if (wvalid && wready) begin
      w_held_reg <= 1'b1;
      w_byte_reg <= wdata[7:0];
      w_lane_reg <= wstrb[0];
    end else if (do_write) begin
      w_held_reg <= 1'b0;
    end
  end

  always_comb begin
    case (aw_index_reg)
      ddc_ctrl_pkg::IDX_PIN_CHOICE,
      ddc_ctrl_pkg::IDX_OSC_CHOICE,
      ddc_ctrl_pkg::IDX_RESET_POLICY,
      ddc_ctrl_pkg::IDX_BAND0_GAIN,
      ddc_ctrl_pkg::IDX_BAND1_GAIN,
      ddc_ctrl_pkg::IDX_LATENCY,
      ddc_ctrl_pkg::IDX_WIDE_GAIN: write_hit = 1'b1;
      default: write_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      bvalid <= 1'b0;
      bresp <= ddc_ctrl_pkg::RESP_OKAY;
    end else if (do_write) begin
      bvalid <= 1'b1;
      bresp <= write_hit ? ddc_ctrl_pkg::RESP_OKAY : ddc_ctrl_pkg::RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // Only the defined field bits are stored, so reserved bits have no effect.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pin_choice_reg <= 1'b0;
      osc_choice_reg <= ddc_ctrl_pkg::OSC_CHOICE_RESET;
      policy_reg <= ddc_ctrl_pkg::POLICY_RESET;
      band0_gain_reg <= 1'b0;
      band1_gain_reg <= 1'b0;
      wide_gain_reg <= 1'b0;
      latency_reg <= ddc_ctrl_pkg::LATENCY_RESET;
    end else if (do_write && w_lane_reg) begin
      case (aw_index_reg)
        ddc_ctrl_pkg::IDX_PIN_CHOICE: begin
          pin_choice_reg <= w_byte_reg[ddc_ctrl_pkg::PIN_CHOICE_BIT];
        end
        ddc_ctrl_pkg::IDX_OSC_CHOICE: begin
          osc_choice_reg <= w_byte_reg[ddc_ctrl_pkg::OSC_CHOICE_LSB +: 2];
        end
        ddc_ctrl_pkg::IDX_RESET_POLICY: begin
          policy_reg <= w_byte_reg[ddc_ctrl_pkg::POLICY_LSB +: 2];
        end
        ddc_ctrl_pkg::IDX_BAND0_GAIN: begin
          band0_gain_reg <= w_byte_reg[ddc_ctrl_pkg::GAIN_BIT];
        end
        ddc_ctrl_pkg::IDX_BAND1_GAIN: begin
          band1_gain_reg <= w_byte_reg[ddc_ctrl_pkg::GAIN_BIT];
        end
        ddc_ctrl_pkg::IDX_LATENCY: begin
          latency_reg <= w_byte_reg[ddc_ctrl_pkg::LATENCY_LSB +: 3];
        end
        ddc_ctrl_pkg::IDX_WIDE_GAIN: begin
          wide_gain_reg <= w_byte_reg[ddc_ctrl_pkg::GAIN_BIT];
        end
        default: begin
          latency_reg <= latency_reg;
        end
      endcase
    end
  end

  assign ar_index = araddr[11:2];

  always_comb begin
    read_hit = 1'b1;
    read_byte = 8'h00;
    case (ar_index)
      ddc_ctrl_pkg::IDX_PIN_CHOICE: read_byte[ddc_ctrl_pkg::PIN_CHOICE_BIT] = pin_choice_reg;
      ddc_ctrl_pkg::IDX_OSC_CHOICE: read_byte[ddc_ctrl_pkg::OSC_CHOICE_LSB +: 2] = osc_choice_reg;
      ddc_ctrl_pkg::IDX_RESET_POLICY: read_byte[ddc_ctrl_pkg::POLICY_LSB +: 2] = policy_reg;
      ddc_ctrl_pkg::IDX_BAND0_GAIN: read_byte[ddc_ctrl_pkg::GAIN_BIT] = band0_gain_reg;
      ddc_ctrl_pkg::IDX_BAND1_GAIN: read_byte[ddc_ctrl_pkg::GAIN_BIT] = band1_gain_reg;
      ddc_ctrl_pkg::IDX_LATENCY: read_byte[ddc_ctrl_pkg::LATENCY_LSB +: 3] = latency_reg;
      ddc_ctrl_pkg::IDX_WIDE_GAIN: read_byte[ddc_ctrl_pkg::GAIN_BIT] = wide_gain_reg;
      default: read_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= ddc_ctrl_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata <= {24'h00_0000, read_byte};
      rresp <= read_hit ? ddc_ctrl_pkg::RESP_OKAY : ddc_ctrl_pkg::RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // Pin choice bypasses the register field entirely.
  assign eff_choice = pin_choice_reg ? gpio_osc_choice : osc_choice_reg;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      band1_osc_word <= 16'h0000;
    end else begin
      case (eff_choice)
        ddc_ctrl_pkg::CHOICE_OSC1: band1_osc_word <= osc1_word;
        ddc_ctrl_pkg::CHOICE_OSC2: band1_osc_word <= osc2_word;
        ddc_ctrl_pkg::CHOICE_OSC3: band1_osc_word <= osc3_word;
        default: band1_osc_word <= osc1_word;
      endcase
    end
  end

  assign fixed_latency = latency_reg;

  reset_policy u_reset_policy (
    .clk_sys(clk_sys),
    .reset(reset),
    .policy(policy_reg),
    .ddc_start(ddc_start),
    .lmfc_event(lmfc_event),
    .divider_resync(divider_resync),
    .dsp_reset(dsp_reset)
  );

  logic signed [15:0] path_in [NPATH];
  logic signed [16:0] path_out [NPATH];
  logic path_en [NPATH];

  assign path_in[0] = band0_in;
  assign path_in[1] = band1_in;
  assign path_in[2] = wide_in;
  // The wideband path sees only its own bit, never the band bits.
  assign path_en[0] = band0_gain_reg;
  assign path_en[1] = band1_gain_reg;
  assign path_en[2] = wide_gain_reg;
  assign band0_out = path_out[0];
  assign band1_out = path_out[1];
  assign wide_out = path_out[2];

  for (genvar i = 0; i < NPATH; i++) begin : g_path
    gain_doubler #(.W(ddc_ctrl_pkg::SAMPLE_W)) u_gain (
      .clk_sys(clk_sys),
      .reset(reset),
      .double_en(path_en[i]),
      .sample_in(path_in[i]),
      .sample_out(path_out[i])
    );
  end

  bvalid_hold_a: assert property (@(posedge clk_sys) disable iff (reset)
    bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("Write response dropped early.");

  rvalid_hold_a: assert property (@(posedge clk_sys) disable iff (reset)
    rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("Read data dropped early.");

  latency_reset_a: assert property (@(posedge clk_sys)
    reset |=> fixed_latency == 3'h5)
    else $error("Latency field reset value wrong.");

  osc_register_a: assert property (@(posedge clk_sys) disable iff (reset)
    !pin_choice_reg && osc_choice_reg == 2'h1 |=> band1_osc_word == $past(osc2_word))
    else $error("Register choice 01 did not pick oscillator_2.");

  osc_pins_a: assert property (@(posedge clk_sys) disable iff (reset)
    pin_choice_reg && gpio_osc_choice == 2'h2 |=> band1_osc_word == $past(osc3_word))
    else $error("Pin choice 10 did not pick oscillator_3.");

  osc_undefined_a: assert property (@(posedge clk_sys) disable iff (reset)
    eff_choice == 2'h3 |=> band1_osc_word == $past(osc1_word))
    else $error("Choice 11 did not pick oscillator_1.");

  wide_isolation_a: assert property (@(posedge clk_sys) disable iff (reset)
    !wide_gain_reg && (band0_gain_reg || band1_gain_reg) |=> wide_out == $past(wide_in))
    else $error("Band gain leaked into wideband path.");

  write_latency_a: assert property (@(posedge clk_sys) disable iff (reset)
    do_write && w_lane_reg && aw_index_reg == 10'h01e |=> fixed_latency == $past(w_byte_reg[6:4]))
    else $error("Latency write not applied.");

  write_error_a: assert property (@(posedge clk_sys) disable iff (reset)
    do_write && !write_hit |=> bvalid && bresp == ddc_ctrl_pkg::RESP_SLVERR)
    else $error("Unmapped write not refused.");

  read_error_a: assert property (@(posedge clk_sys) disable iff (reset)
    arvalid && arready && !read_hit |=> rvalid && rresp == ddc_ctrl_pkg::RESP_SLVERR)
    else $error("Unmapped read not refused.");

  read_reserved_a: assert property (@(posedge clk_sys) disable iff (reset)
    rvalid |-> rdata[31:8] == 24'h00_0000)
    else $error("Reserved read bits not zero.");

  osc_first_a: assert property (@(posedge clk_sys) disable iff (reset)
    !reset && !pin_choice_reg && osc_choice_reg == 2'h0 |=> band1_osc_word == $past(osc1_word))
    else $error("Register choice 00 did not pick oscillator_1.");

  osc_third_a: assert property (@(posedge clk_sys) disable iff (reset)
    !reset && !pin_choice_reg && osc_choice_reg == 2'h2 |=> band1_osc_word == $past(osc3_word))
    else $error("Register choice 10 did not pick oscillator_3.");

  band0_gain_a: assert property (@(posedge clk_sys) disable iff (reset)
    band0_gain_reg |=> band0_out == $past(band0_in) * 2)
    else $error("First band output not doubled.");

  wide_gain_a: assert property (@(posedge clk_sys) disable iff (reset)
    wide_gain_reg |=> wide_out == $past(wide_in) * 2)
    else $error("Wideband output not doubled.");

endmodule
`default_nettype wire

// ==== bench/tb_downconverter_control_regs.sv ====
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin failures++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module tb_downconverter_control_regs;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, reset, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, dsp_reset;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, gpio_osc_choice;
  logic [15:0] osc1_word, osc2_word, osc3_word, band1_osc_word;
  logic ddc_start, lmfc_event, divider_resync;
  logic signed [15:0] band0_in, band1_in, wide_in;
  logic signed [16:0] band0_out, band1_out, wide_out;
  logic [2:0] fixed_latency;
  int failures = 0;
  int tests_run = 0;
  int cycles = 0;
  logic [15:0] osc_exp [4];
  logic [7:0] lat_set [4];
  logic [3:0] wr_strb;

  downconverter_control_regs u_downconverter_control_regs (.clk_sys(clk_sys), .reset(reset),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
    .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
    .rdata(rdata), .rresp(rresp), .osc1_word(osc1_word), .osc2_word(osc2_word),
    .osc3_word(osc3_word), .gpio_osc_choice(gpio_osc_choice), .band1_osc_word(band1_osc_word),
    .ddc_start(ddc_start), .lmfc_event(lmfc_event), .divider_resync(divider_resync),
    .dsp_reset(dsp_reset), .band0_in(band0_in), .band1_in(band1_in), .wide_in(wide_in),
    .band0_out(band0_out), .band1_out(band1_out), .wide_out(wide_out),
    .fixed_latency(fixed_latency));

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // The ceiling is far above the few hundred cycles the sequence needs.
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles >= 20000) begin
      failures++;
      give_verdict();
    end
  end

  function automatic logic [11:0] ba(input logic [9:0] idx);
    return {idx, 2'h0};
  endfunction

  task automatic wr(input logic [9:0] idx, input logic [31:0] d, input logic [1:0] er);
    int n;
    logic ta, tw, gotb;
    n = 0;
    gotb = 1'b0;
    @(posedge clk_sys);
    awaddr <= ba(idx);
    wdata <= d;
    wstrb <= wr_strb;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!gotb && n < 50) begin
      @(negedge clk_sys);
      ta = awvalid && awready;
      tw = wvalid && wready;
      gotb = bvalid && bready;
      if (gotb) `CHK("bresp", er, bresp)
      @(posedge clk_sys);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      n++;
    end
    bready <= 1'b0;
    if (!gotb) `CHK("write answer", 1'b1, 1'b0)
  endtask

  task automatic rd(input logic [9:0] idx, input logic [31:0] ed, input logic [1:0] er);
    int n;
    logic ta, gotr;
    n = 0;
    gotr = 1'b0;
    @(posedge clk_sys);
    araddr <= ba(idx);
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!gotr && n < 50) begin
      @(negedge clk_sys);
      ta = arvalid && arready;
      gotr = rvalid && rready;
      if (gotr) `CHK("rdata", ed, rdata)
      if (gotr) `CHK("rresp", er, rresp)
      @(posedge clk_sys);
      if (ta) arvalid <= 1'b0;
      n++;
    end
    rready <= 1'b0;
    if (!gotr) `CHK("read answer", 1'b1, 1'b0)
  endtask

  // One event pulse; the converter reset must follow after one cycle exactly exp_cnt times, zero or once.
  task automatic ev(input int k, input int exp_cnt);
    logic [3:0] cnt;
    cnt = 4'h0;
    @(posedge clk_sys);
    if (k == 0) ddc_start <= 1'b1;
    if (k == 1) lmfc_event <= 1'b1;
    if (k == 2) divider_resync <= 1'b1;
    @(posedge clk_sys);
    ddc_start <= 1'b0;
    lmfc_event <= 1'b0;
    divider_resync <= 1'b0;
    @(negedge clk_sys);
    `CHK("dsp_reset timing", (exp_cnt > 0), dsp_reset)
    cnt += dsp_reset;
    repeat (3) begin
      @(negedge clk_sys);
      cnt += dsp_reset;
    end
    `CHK("dsp_reset count", 4'(exp_cnt), cnt)
  endtask

  function automatic logic [16:0] scaled(input logic [15:0] x, input logic g);
    return g ? {x, 1'b0} : {x[15], x};
  endfunction

  task automatic paths(input logic g0, input logic g1, input logic gw);
    wr(ddc_ctrl_pkg::IDX_BAND0_GAIN, {31'h0, g0}, 2'h0);
    wr(ddc_ctrl_pkg::IDX_BAND1_GAIN, {31'h0, g1}, 2'h0);
    wr(ddc_ctrl_pkg::IDX_WIDE_GAIN, {31'h0, gw}, 2'h0);
    repeat (3) @(negedge clk_sys);
    `CHK("band0_out", scaled(band0_in, g0), band0_out)
    `CHK("band1_out", scaled(band1_in, g1), band1_out)
    `CHK("wide_out", scaled(wide_in, gw), wide_out)
  endtask

  initial begin
    reset = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    {ddc_start, lmfc_event, divider_resync} = 3'h0;
    awaddr = 12'h000;
    araddr = 12'h000;
    wdata = 32'h0;
    wstrb = 4'h0;
    wr_strb = 4'hf;
    gpio_osc_choice = 2'h0;
    osc1_word = 16'h1111;
    osc2_word = 16'h2222;
    osc3_word = 16'h3333;
    osc_exp = '{16'h1111, 16'h2222, 16'h3333, 16'h1111};
    lat_set = '{ddc_ctrl_pkg::LATENCY_DEC_24_32, ddc_ctrl_pkg::LATENCY_DEC_16_20,
      ddc_ctrl_pkg::LATENCY_DEC_6_12, ddc_ctrl_pkg::LATENCY_DEC_4_10};
    band0_in = 16'h8001;
    band1_in = 16'h7fff;
    wide_in = 16'hc000;
    repeat (4) @(posedge clk_sys);
    reset <= 1'b0;
    @(negedge clk_sys);
    `CHK("fixed_latency reset", 3'h5, fixed_latency)
    rd(ddc_ctrl_pkg::IDX_LATENCY, 32'h50, 2'h0);
    rd(ddc_ctrl_pkg::IDX_OSC_CHOICE, 32'h0, 2'h0);
    rd(ddc_ctrl_pkg::IDX_RESET_POLICY, 32'h0, 2'h0);
    rd(ddc_ctrl_pkg::IDX_BAND0_GAIN, 32'h0, 2'h0);
    rd(ddc_ctrl_pkg::IDX_BAND1_GAIN, 32'h0, 2'h0);
    rd(ddc_ctrl_pkg::IDX_PIN_CHOICE, 32'h0, 2'h0);
    rd(ddc_ctrl_pkg::IDX_WIDE_GAIN, 32'h0, 2'h0);
    rd(10'h100, 32'h0, 2'h2);
    wr(10'h100, 32'h1, 2'h2);
    wr_strb = 4'he;
    wr(ddc_ctrl_pkg::IDX_BAND0_GAIN, 32'h1, 2'h0);
    wr_strb = 4'hf;
    rd(ddc_ctrl_pkg::IDX_BAND0_GAIN, 32'h0, 2'h0);
    wr(ddc_ctrl_pkg::IDX_OSC_CHOICE, 32'hff, 2'h0);
    rd(ddc_ctrl_pkg::IDX_OSC_CHOICE, 32'h03, 2'h0);
    for (int c = 0; c < 4; c++) begin
      wr(ddc_ctrl_pkg::IDX_OSC_CHOICE, c, 2'h0);
      gpio_osc_choice <= 2'(3 - c);
      repeat (3) @(negedge clk_sys);
      `CHK("band1_osc_word by register", osc_exp[c], band1_osc_word)
    end
    wr(ddc_ctrl_pkg::IDX_PIN_CHOICE, 32'h1, 2'h0);
    rd(ddc_ctrl_pkg::IDX_PIN_CHOICE, 32'h1, 2'h0);
    for (int c = 0; c < 4; c++) begin
      gpio_osc_choice <= 2'(c);
      repeat (3) @(negedge clk_sys);
      `CHK("band1_osc_word by pins", osc_exp[c], band1_osc_word)
    end
    paths(1'b0, 1'b0, 1'b0);
    paths(1'b1, 1'b0, 1'b0);
    paths(1'b0, 1'b1, 1'b1);
    paths(1'b1, 1'b1, 1'b0);
    foreach (lat_set[i]) begin
      wr(ddc_ctrl_pkg::IDX_LATENCY, {24'h00_0000, lat_set[i]}, 2'h0);
      rd(ddc_ctrl_pkg::IDX_LATENCY, {24'h00_0000, lat_set[i]}, 2'h0);
      @(negedge clk_sys);
      `CHK("fixed_latency", lat_set[i][6:4], fixed_latency)
    end
    wr(ddc_ctrl_pkg::IDX_LATENCY, 32'hff, 2'h0);
    rd(ddc_ctrl_pkg::IDX_LATENCY, 32'h70, 2'h0);
    wr(ddc_ctrl_pkg::IDX_RESET_POLICY, 32'h0, 2'h0);
    ev(1, 1);
    ev(1, 1);
    ev(0, 0);
    wr(ddc_ctrl_pkg::IDX_RESET_POLICY, 32'h3, 2'h0);
    ev(1, 0);
    ev(0, 1);
    ev(2, 0);
    ev(1, 0);
    wr(ddc_ctrl_pkg::IDX_RESET_POLICY, 32'h1, 2'h0);
    ev(0, 0);
    ev(1, 1);
    ev(1, 0);
    ev(2, 0);
    ev(1, 1);
    ev(1, 0);
    wr(ddc_ctrl_pkg::IDX_RESET_POLICY, 32'h2, 2'h0);
    ev(0, 0);
    ev(1, 1);
    ev(2, 0);
    ev(1, 1);
    ev(1, 1);
    ev(1, 0);
    give_verdict();
  end
endmodule
`default_nettype wire
